// ===== common/dia_pkg.sv
/*
 * constants, enumerations and carrier structs of the digital input alarm channel.
 * assumes a 32-bit avalon-mm slave port with byte addresses, one word per register.
 */
package dia_pkg;

	// ----------------------------------------------------------------
	// bus geometry and register map
	// ----------------------------------------------------------------
	localparam int         DIA_AW           = 5;     // byte address width
	localparam int         DIA_DW           = 32;    // data width
	localparam int         DIA_BE           = 4;     // byte enables
	localparam logic [4:0] DIA_OFF_CTRL     = 5'h00; // channel configuration
	localparam logic [4:0] DIA_OFF_STAT     = 5'h04; // live channel state
	localparam logic [4:0] DIA_OFF_CLR      = 5'h08; // clear commands
	localparam logic [4:0] DIA_OFF_IRQ_STAT = 5'h0c; // sticky events
	localparam logic [4:0] DIA_OFF_IRQ_MASK = 5'h10; // event enables
	localparam int         DIA_CLR_ALARM    = 0;     // manual alarm clear bit
	localparam int         DIA_CLR_LATCH    = 1;     // latched flag clear bit
	localparam logic [2:0] DIA_SEV_CRIT     = 3'h2;  // critical severity code

	typedef logic [DIA_DW-1:0] dia_word_t;           // one bus word

	// ----------------------------------------------------------------
	// modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DIA_TRIG_OFF   = 2'h0, // no alarm
		DIA_TRIG_INACT = 2'h1, // alarm on going inactive
		DIA_TRIG_ACT   = 2'h2  // alarm on going active
	} dia_trig_e;

	typedef enum logic [1:0] {
		DIA_LATCH_NONE = 2'h0, // nothing captured
		DIA_LATCH_RISE = 2'h1, // capture inactive to active
		DIA_LATCH_FALL = 2'h2  // capture active to inactive
	} dia_latch_e;

	// ----------------------------------------------------------------
	// register layouts, lsb last
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       out_mode;   // 1 = drive the line, 0 = input mode
		logic       trap_en;    // trap notification enable
		logic       log_en;     // log notification enable
		logic       email_en;   // email notification enable
		logic       manual_clr; // manual clear mode
		logic       auto_clr;   // automatic clear mode
		dia_trig_e  trig;       // alarm trigger setting
		dia_latch_e latch;      // latch setting
		logic       invert;     // invert reported level
	} dia_ctrl_s;

	typedef struct packed {
		logic alarm;   // alarm raised
		logic latched; // transition captured
		logic level;   // reported level after inversion
		logic raw;     // synchronised line
	} dia_stat_s;

	typedef struct packed {
		logic latch_ev; // transition captured
		logic clear_ev; // alarm cleared
		logic raise_ev; // alarm raised
	} dia_irq_s;

	typedef struct packed {
		logic       email;    // email event pulse
		logic       log;      // log event pulse
		logic       trap;     // trap event pulse
		logic       raised;   // 1 = raised, 0 = cleared
		logic       value;    // level that caused the event
		logic [2:0] severity; // severity code
	} dia_ntf_s;

	localparam dia_ctrl_s DIA_CTRL_RST = '{trig: DIA_TRIG_OFF, latch: DIA_LATCH_NONE,
		auto_clr: 1'b1, default: 1'b0};

endpackage : dia_pkg

// ===== logic/dia_channel.sv
/*
 * one digital input channel: synchroniser, inversion, latch, alarm with
 * automatic or manual clear, notification events, avalon-mm registers, irq.
 * assumes the line is asynchronous to sys_clk_in and ce_in, the bus and the
 * notification sink are on sys_clk_in.
 */
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
module dia_channel
	import dia_pkg::*;
(
	input  wire logic             sys_clk_in,          // 10 mhz clock
	input  wire logic             resetn_in,           // async reset, low
	input  wire logic             ce_in,               // clock enable
	input  wire logic [DIA_AW-1:0] avs_address_in,     // byte address
	input  wire logic             avs_read_in,         // read request
	input  wire logic             avs_write_in,        // write request
	input  wire logic [DIA_DW-1:0] avs_writedata_in,   // write data
	input  wire logic [DIA_BE-1:0] avs_byteenable_in,  // byte lanes
	output logic      [DIA_DW-1:0] avs_readdata_out,   // read data
	output logic                  avs_waitrequest_out, // stall
	input  wire logic             line_in,             // input line
	output logic                  line_out,            // line drive level
	output logic                  line_oe_out,         // line drive enable
	output dia_ntf_s              ntf_out,             // notification events
	output logic                  irq_out              // level interrupt
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic      sync1;   // first synchroniser stage
		logic      sync2;   // second synchroniser stage
		logic      lvl;     // previous reported level
		dia_ctrl_s ctrl;    // configuration
		logic      alarm;   // alarm raised
		logic      latched; // captured transition
		dia_irq_s  ists;    // sticky events
		dia_irq_s  imask;   // event mask
		logic      irq;     // interrupt output
		logic      wait_q;  // waitrequest
		dia_word_t rdata;   // read data
		dia_ntf_s  ntf;     // notification output
		logic      oe;      // line drive enable
		logic      drv;     // line drive level
	} dia_state_s;

	localparam dia_state_s ST_RST = '{ctrl: DIA_CTRL_RST, ists: '0, imask: '0,
		ntf: '0, rdata: '0, wait_q: 1'b1, default: 1'b0};

	dia_state_s s_q;      // registered state
	dia_state_s s_d;      // next state
	logic       lvl_now;  // reported level this cycle
	logic       rise;     // inactive to active
	logic       fall;     // active to inactive
	logic       hit;      // trigger condition met
	logic       back;     // non-triggering condition
	logic       raise_ev; // alarm raised now
	logic       clear_ev; // alarm cleared now
	logic       cap;      // latch captures now
	logic       req;      // bus request present
	logic       take;     // request accepted, data staged
	logic       done;     // request completes
	logic       wr_do;    // write takes effect
	logic       clr_alm;  // manual clear request
	logic       clr_lat;  // latch clear request
	dia_ctrl_s  ctrl_w;   // ctrl after write
	dia_stat_s  stat;     // live status word

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// merge write data into an old word by byte lanes
	function automatic dia_word_t lane_merge(dia_word_t old_w, dia_word_t new_w,
		logic [DIA_BE-1:0] be);
		dia_word_t res;
		res = old_w;
		for (int i = 0; i < DIA_BE; i++)
		begin
			if (be[i])
			begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// one process computes every next value; ce_in low keeps all state
	always_comb
	begin
		s_d      = s_q;
		lvl_now  = s_q.sync2 ^ s_q.ctrl.invert;
		rise     = lvl_now & ~s_q.lvl;
		fall     = ~lvl_now & s_q.lvl;
		req      = avs_read_in | avs_write_in;
		take     = req & s_q.wait_q;
		done     = req & ~s_q.wait_q;
		wr_do    = avs_write_in & done;
		clr_alm  = wr_do & (avs_address_in == DIA_OFF_CLR) & avs_byteenable_in[0]
			& avs_writedata_in[DIA_CLR_ALARM];
		clr_lat  = wr_do & (avs_address_in == DIA_OFF_CLR) & avs_byteenable_in[0]
			& avs_writedata_in[DIA_CLR_LATCH];
		// trigger and return conditions per setting
		case (s_q.ctrl.trig)
			DIA_TRIG_INACT:
			begin
				hit  = fall;
				back = lvl_now;
			end
			DIA_TRIG_ACT:
			begin
				hit  = rise;
				back = ~lvl_now;
			end
			default:
			begin
				hit  = 1'b0;
				back = 1'b1;
			end
		endcase
		raise_ev = ~s_q.alarm & hit;
		// auto clear follows the line, manual waits for software
		clear_ev = s_q.alarm & ((s_q.ctrl.auto_clr & back)
			| (s_q.ctrl.manual_clr & clr_alm));
		cap      = ((s_q.ctrl.latch == DIA_LATCH_RISE) & rise)
			| ((s_q.ctrl.latch == DIA_LATCH_FALL) & fall);
		stat     = '{alarm: s_q.alarm, latched: s_q.latched, level: lvl_now, raw: s_q.sync2};
		ctrl_w   = dia_ctrl_s'(lane_merge(dia_word_t'(s_q.ctrl), avs_writedata_in,
			avs_byteenable_in));
		if (ce_in)
		begin
			// first stage feeds only the second stage
			s_d.sync1   = line_in;
			s_d.sync2   = s_q.sync1;
			s_d.lvl     = lvl_now;
			// alarm state
			if (raise_ev)
			begin
				s_d.alarm = 1'b1;
			end
			else if (clear_ev)
			begin
				s_d.alarm = 1'b0;
			end
			// latch: capture beats a clear in the same cycle
			s_d.latched = cap | (s_q.latched & ~clr_lat);
			// notification pulses
			s_d.ntf.email    = s_q.ctrl.email_en & (raise_ev | clear_ev);
			s_d.ntf.log      = s_q.ctrl.log_en & (raise_ev | clear_ev);
			s_d.ntf.trap     = s_q.ctrl.trap_en & (raise_ev | clear_ev);
			s_d.ntf.raised   = raise_ev;
			s_d.ntf.value    = lvl_now;
			s_d.ntf.severity = DIA_SEV_CRIT;
			// register writes
			if (wr_do && avs_address_in == DIA_OFF_CTRL)
			begin
				s_d.ctrl          = ctrl_w;
				s_d.ctrl.auto_clr = ~ctrl_w.manual_clr;
			end
			if (wr_do && avs_address_in == DIA_OFF_IRQ_MASK)
			begin
				s_d.imask = dia_irq_s'(lane_merge(dia_word_t'(s_q.imask),
					avs_writedata_in, avs_byteenable_in));
			end
			// sticky events: a new event wins over the write-one clear
			s_d.ists = s_q.ists;
			if (wr_do && avs_address_in == DIA_OFF_IRQ_STAT)
			begin
				s_d.ists = s_q.ists & ~dia_irq_s'(lane_merge('0, avs_writedata_in,
					avs_byteenable_in));
			end
			s_d.ists = s_d.ists | dia_irq_s'{latch_ev: cap, clear_ev: clear_ev, raise_ev: raise_ev};
			s_d.irq  = |(s_d.ists & s_d.imask);
			// handshake: one wait cycle, data staged at the taking edge
			if (take)
			begin
				s_d.wait_q = 1'b0;
				case (avs_address_in)
					DIA_OFF_CTRL:     s_d.rdata = dia_word_t'(s_q.ctrl);  // configuration
					DIA_OFF_STAT:     s_d.rdata = dia_word_t'(stat);      // live state
					DIA_OFF_IRQ_STAT: s_d.rdata = dia_word_t'(s_q.ists);  // sticky events
					DIA_OFF_IRQ_MASK: s_d.rdata = dia_word_t'(s_q.imask); // event enables
					default:          s_d.rdata = '0;                     // clear and unmapped read 0
				endcase
			end
			else if (done)
			begin
				s_d.wait_q = 1'b1;
			end
			// drive only in output mode; level fixed low
			s_d.oe  = s_q.ctrl.out_mode;
			s_d.drv = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset loads constants only
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s_q <= ST_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata_out    = s_q.rdata;
	assign avs_waitrequest_out = s_q.wait_q;
	assign line_out            = s_q.drv;
	assign line_oe_out         = s_q.oe;
	assign ntf_out             = s_q.ntf;
	assign irq_out             = s_q.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);

	// reported level moved up with trigger active
	sequence seq_rise_act;
		ce_in && s_q.ctrl.trig == DIA_TRIG_ACT && !s_q.alarm && rise;
	endsequence

	// reported level moved down with trigger inactive
	sequence seq_fall_inact;
		ce_in && s_q.ctrl.trig == DIA_TRIG_INACT && !s_q.alarm && fall;
	endsequence

	// an alarm transition seen from outside
	sequence seq_alarm_moved;
		ce_in && (raise_ev || clear_ev);
	endsequence

	AST_SYNC_TWO: assert property (
		resetn_in && ce_in ##1 ce_in |=> s_q.sync2 == $past(line_in, 2))
		else $error("line reached logic not after two stages");

	AST_INVERT: assert property (
		ce_in |=> s_q.lvl == ($past(s_q.sync2) ^ $past(s_q.ctrl.invert)))
		else $error("reported level ignores inversion");

	AST_TRIG_OFF: assert property (
		ce_in && s_q.ctrl.trig == DIA_TRIG_OFF && !s_q.alarm |=> !s_q.alarm)
		else $error("alarm raised while trigger disabled");

	AST_TRIG_INACT: assert property (
		seq_fall_inact |=> s_q.alarm && s_q.ists.raise_ev)
		else $error("falling level did not raise alarm");

	AST_TRIG_ACT: assert property (
		seq_rise_act |=> s_q.alarm ##1 (s_q.alarm || !ce_in || $past(clear_ev)))
		else $error("rising level did not raise alarm");

	AST_AUTO_CLR: assert property (
		ce_in && s_q.alarm && s_q.ctrl.auto_clr && s_q.ctrl.trig == DIA_TRIG_ACT
		&& !lvl_now |=> !s_q.alarm)
		else $error("auto clear did not end alarm");

	AST_MANUAL_HOLD: assert property (
		ce_in && s_q.alarm && s_q.ctrl.manual_clr && !clr_alm |=> s_q.alarm)
		else $error("manual alarm ended without clear request");

	AST_EMAIL: assert property (
		(seq_alarm_moved and s_q.ctrl.email_en) |=> ntf_out.email
		&& ntf_out.severity == DIA_SEV_CRIT && ntf_out.value == $past(lvl_now))
		else $error("email event missing or wrong");

	AST_LOG: assert property (
		ce_in && s_q.ctrl.log_en |=> ntf_out.log == $past(raise_ev || clear_ev))
		else $error("log event does not track alarm changes");

	AST_TRAP: assert property (
		(seq_alarm_moved and s_q.ctrl.trap_en) |=> ntf_out.trap && ntf_out.raised == s_q.alarm)
		else $error("trap event missing or flag wrong");

	AST_LATCH_HOLD: assert property (
		s_q.latched && !(ce_in && clr_lat) |=> s_q.latched)
		else $error("latched transition lost without clear");

	AST_NO_DRIVE: assert property (
		!s_q.ctrl.out_mode [*2] |-> !line_oe_out)
		else $error("line driven in input mode");

	AST_EXCLUSIVE: assert property (
		s_q.ctrl.auto_clr != s_q.ctrl.manual_clr)
		else $error("clear modes not exclusive");

	AST_BUS_ONE_WAIT: assert property (
		ce_in && req && s_q.wait_q |=> !avs_waitrequest_out)
		else $error("bus request not answered after one wait cycle");

	// manual clear request with an alarm up
	sequence seq_manual_req;
		ce_in && s_q.alarm && s_q.ctrl.manual_clr && clr_alm;
	endsequence

	// the clear request ends a manual alarm at its completion edge
	AST_MANUAL_CLR: assert property (
		seq_manual_req |=> !s_q.alarm && s_q.ists.clear_ev)
		else $error("manual clear request did not end alarm");

	// a captured transition shows in status and in the sticky bits
	AST_LATCH_CAP: assert property (
		ce_in && cap |=> s_q.latched && s_q.ists.latch_ev)
		else $error("transition not captured");

	// a raise event survives a write-one clear in the same cycle
	AST_STICKY_WINS: assert property (
		ce_in && raise_ev |=> s_q.ists.raise_ev)
		else $error("raise event lost in sticky status");

	// the interrupt follows the unmasked sticky bits
	AST_IRQ_LEVEL: assert property (
		$past(ce_in) |-> irq_out == |(s_q.ists & s_q.imask))
		else $error("interrupt level does not match status and mask");

	// clock enable low keeps every state bit
	AST_CE_FREEZE: assert property (
		!ce_in |=> $stable(s_q))
		else $error("state moved while clock enable low");

endmodule : dia_channel

// ===== tb/dia_sensor.sv
/*
 * contact model of the sensor wired to the channel's input line.
 * assumes the bench sets the contact level; the channel may drive the wire.
 */
`timescale 1ns/1ns
module dia_sensor
(
	input  wire logic contact_in, // contact level, high = active
	input  wire logic drv_in,     // channel drive level
	input  wire logic oe_in,      // channel drive enable
	output logic      line_out    // resolved wire level
);
	// the channel owns the wire only while its enable is up
	assign line_out = oe_in ? drv_in : contact_in;
endmodule : dia_sensor

// ===== tb/tb_digital_input_alarm_channel.sv
/*
 * bench of the digital input alarm channel: a row table, then hand cases.
 * assumes dia_pkg and dia_sensor are compiled before it.
 */
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_digital_input_alarm_channel
	import dia_pkg::*;
;
	typedef struct packed {
		logic [11:0] ctrl; // control word written
		logic        line; // contact level
		logic [3:0]  stat; // {alarm, latched, level, raw}
		logic [1:0]  ev;   // pulses of each kind
		logic        rsd;  // raised flag of last event
	} dia_row_s;
	localparam dia_row_s ROWS [9] = '{
		'{12'h000, 1'b1, 4'h3, 2'h0, 1'b0}, '{12'h000, 1'b0, 4'h0, 2'h0, 1'b0},
		'{12'h390, 1'b1, 4'hb, 2'h1, 1'b1}, '{12'h390, 1'b0, 4'h0, 2'h1, 1'b0},
		'{12'h008, 1'b1, 4'h3, 2'h0, 1'b0}, '{12'h008, 1'b0, 4'h8, 2'h0, 1'b0},
		'{12'h008, 1'b1, 4'h3, 2'h0, 1'b0}, '{12'h001, 1'b1, 4'h1, 2'h0, 1'b0},
		'{12'h003, 1'b0, 4'h6, 2'h0, 1'b0}};
	logic             sys_clk_in, resetn_in, ce_in, contact, line, line_out, line_oe_out, irq_out;
	logic [DIA_AW-1:0] avs_address_in;
	logic             avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [DIA_BE-1:0] avs_byteenable_in;
	dia_word_t        avs_writedata_in, avs_readdata_out, rd;
	dia_ntf_s         ntf_out;
	logic             last_r, last_v;
	int               miscompares, comparisons, cycles, n_em, n_lg, n_tp, sev_bad, n;

	dia_channel dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.line_in(line), .line_out(line_out), .line_oe_out(line_oe_out), .ntf_out(ntf_out), .irq_out(irq_out));
	dia_sensor sensor (.contact_in(contact), .drv_in(line_out), .oe_in(line_oe_out), .line_out(line));

	// ----------------------------------------------------------------
	// clock, timeout and event monitor
	// ----------------------------------------------------------------
	initial
	begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	// count event pulses and keep what the last one carried
	always @(posedge sys_clk_in)
	begin
		if (ntf_out.email === 1'b1) n_em++;
		if (ntf_out.log === 1'b1) n_lg++;
		if (ntf_out.trap === 1'b1) n_tp++;
		if ((ntf_out.email | ntf_out.log | ntf_out.trap) === 1'b1)
		begin
			last_r = ntf_out.raised;
			last_v = ntf_out.value;
			if (ntf_out.severity !== DIA_SEV_CRIT) sev_bad++;
		end
	end

	// ----------------------------------------------------------------
	// bus and line tasks
	// ----------------------------------------------------------------
	// one access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input dia_word_t d);
		@(posedge sys_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= ~w;
		// wait for the answer; only the bench timeout ends a stall
		do
			@(posedge sys_clk_in);
		while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask : bus
	task automatic wr(input logic [4:0] a, input dia_word_t d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input string nm, input logic [4:0] a, input dia_word_t e);
		bus(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask : rdchk
	task automatic setl(input logic v);
		@(posedge sys_clk_in);
		contact <= v;
	endtask : setl
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		resetn_in = 1'b0;
		ce_in = 1'b1;
		avs_address_in = '0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = '0;
		avs_byteenable_in = 4'hf;
		contact = 1'b0;
		repeat (16) @(posedge sys_clk_in);
		`CHK("oe", 1'b0, line_oe_out)
		`CHK("ntf", 8'h00, ntf_out)
		resetn_in <= 1'b1;
		rdchk("ctrl", DIA_OFF_CTRL, 32'h20);
		rdchk("mask", DIA_OFF_IRQ_MASK, 32'h0);
		rdchk("unmapped", 5'h14, 32'h0);
		// table rows: configuration, line level, settled state and events
		foreach (ROWS[i])
		begin
			wr(DIA_OFF_CTRL, {20'h0, ROWS[i].ctrl});
			rdchk("ctrl", DIA_OFF_CTRL, {20'h0, ROWS[i].ctrl | 12'h020});
			n_em = 0;
			n_lg = 0;
			n_tp = 0;
			setl(ROWS[i].line);
			repeat (6) @(posedge sys_clk_in);
			rdchk("stat", DIA_OFF_STAT, {28'h0, ROWS[i].stat});
			`CHK("email", ROWS[i].ev, n_em[1:0])
			`CHK("log", ROWS[i].ev, n_lg[1:0])
			`CHK("trap", ROWS[i].ev, n_tp[1:0])
			if (ROWS[i].ev != 2'h0)
			begin
				`CHK("raised", ROWS[i].rsd, last_r)
				`CHK("value", ROWS[i].stat[1], last_v)
			end
		end
		// latched flag clear, then capture of a falling reported level
		wr(DIA_OFF_CLR, 32'h2);
		rdchk("stat", DIA_OFF_STAT, 32'h2);
		wr(DIA_OFF_CTRL, 32'h005);
		setl(1'b1);
		repeat (6) @(posedge sys_clk_in);
		rdchk("stat", DIA_OFF_STAT, 32'h5);
		rdchk("irq stat", DIA_OFF_IRQ_STAT, 32'h7);
		wr(DIA_OFF_IRQ_STAT, 32'h7);
		rdchk("irq stat", DIA_OFF_IRQ_STAT, 32'h0);
		`CHK("irq", 1'b0, irq_out)
		// manual clear with the raise event unmasked
		wr(DIA_OFF_CTRL, 32'h000);
		setl(1'b0);
		repeat (6) @(posedge sys_clk_in);
		wr(DIA_OFF_CLR, 32'h2);
		wr(DIA_OFF_IRQ_STAT, 32'h7);
		wr(DIA_OFF_IRQ_MASK, 32'h1);
		wr(DIA_OFF_CTRL, 32'h250);
		rdchk("ctrl", DIA_OFF_CTRL, 32'h250);
		setl(1'b1);
		n = 0;
		while (ntf_out.trap !== 1'b1 && n < 10)
		begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		`CHK("latency", 3, n)
		`CHK("trap raised", 1'b1, ntf_out.raised)
		`CHK("email off", 1'b0, ntf_out.email)
		setl(1'b0);
		repeat (6) @(posedge sys_clk_in);
		rdchk("stat", DIA_OFF_STAT, 32'h8);
		`CHK("irq", 1'b1, irq_out)
		wr(DIA_OFF_CLR, 32'h1);
		repeat (2) @(posedge sys_clk_in);
		rdchk("stat", DIA_OFF_STAT, 32'h0);
		rdchk("irq stat", DIA_OFF_IRQ_STAT, 32'h3);
		wr(DIA_OFF_IRQ_STAT, 32'h1);
		repeat (2) @(posedge sys_clk_in);
		`CHK("irq", 1'b0, irq_out)
		wr(DIA_OFF_CTRL, 32'h060);
		rdchk("ctrl", DIA_OFF_CTRL, 32'h040);
		// output mode raises the drive enable, input mode drops it
		wr(DIA_OFF_CTRL, 32'h400);
		repeat (2) @(posedge sys_clk_in);
		`CHK("oe", 1'b1, line_oe_out)
		`CHK("drive", 1'b0, line_out)
		wr(DIA_OFF_CTRL, 32'h000);
		repeat (2) @(posedge sys_clk_in);
		`CHK("oe", 1'b0, line_oe_out)
		// clock enable low: a one-cycle pulse on the line must leave no capture
		wr(DIA_OFF_CTRL, 32'h002);
		ce_in <= 1'b0;
		setl(1'b1);
		setl(1'b0);
		repeat (3) @(posedge sys_clk_in);
		ce_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		rdchk("frozen stat", DIA_OFF_STAT, 32'h0);
		`CHK("severity", 0, sev_bad)
		// second reset in mid-run
		resetn_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		rdchk("ctrl", DIA_OFF_CTRL, 32'h20);
		// one byte lane only: upper control bits keep their value, codes 3 act as off and none
		avs_byteenable_in <= 4'h1;
		wr(DIA_OFF_CTRL, 32'h7ff);
		avs_byteenable_in <= 4'hf;
		rdchk("lane", DIA_OFF_CTRL, 32'h0df);
		rdchk("code 3", DIA_OFF_STAT, 32'h2);
		end_of_test();
	end
endmodule : tb_digital_input_alarm_channel
